// file: logic/dkac_key_shift.sv
// key shift register and signature compare
`timescale 1ns/1ps
module dkac_key_shift import dkac_pkg::*; (
  input wire logic clock, // 200 mhz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic key_start, // new key transfer begins
  input wire logic key_valid, // key byte strobe
  input wire logic [7:0] key_byte, // key byte, low byte first
  output dkac_keys_t key_hit // one-cycle match pulses
);
  logic [63:0] shreg;
  logic [3:0] count;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shreg <= 64'h0;
      count <= 4'h0;
    end else if (key_start) begin
      count <= 4'h0;
    end else if (key_valid && count < 4'(KEY_BYTES)) begin
      shreg <= {key_byte, shreg[63:8]};
      count <= count + 4'h1;
    end
  end

  // bytes past the eighth are ignored so a key is exactly 64 bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      key_hit <= '0;
    end else begin
      key_hit <= '0;
      if (key_valid && !key_start && count == 4'(KEY_BYTES - 1)) begin
        key_hit.erase <= ({key_byte, shreg[63:8]} == KEY_ERASE);
        key_hit.prog <= ({key_byte, shreg[63:8]} == KEY_PROG);
        key_hit.urow <= ({key_byte, shreg[63:8]} == KEY_UROW);
      end
    end
  end
endmodule // dkac_key_shift

// file: logic/dkac_pkg.sv
// package: constants and types for the debug key access control block
// Operation
// - system info block is returned on request, whatever the lock state
// - size 16 returns all info bytes, size 8 only family_identifier, as ascii
// - info layout: family 0-6, reserved 7, memctrl 8-10, debug 11-13, 14, osc 15
// - 64-bit key shifted low byte first, compared with erase, prog, user-row keys
// - erase key unconditional; prog key needs unlocked; user-row key needs locked
// - each accepted key sets a readable status flag
// - signature to reset request asserts system reset; 0x00 releases it
// - lock flag clears when erase finishes; host polls until zero
// - system bus refused while locked; full access after erase
// - brown-out detector forced on during chip erase
// - direct memory and flash writes allowed only when unlocked
// - active flag clears when copy ends; host clears key, pulses reset
// - user-row mode accepts ram writes only to first 32 byte addresses
// - buffer copied into user row byte for byte at the same offsets
// - ram reads from the link blocked while user-row mode is active
// - level event per rising edge of the synch character, never disabled
// - block has no event inputs, only generates events
// - keys exactly 64 bits, info readout at most 128 bits, no key response
package dkac_pkg;
  localparam logic [63:0] KEY_ERASE = 64'h4e564d4572617365;
  localparam logic [63:0] KEY_PROG = 64'h4e564d50726f6720;
  localparam logic [63:0] KEY_UROW = 64'h4e564d5573267465;
  localparam int KEY_BYTES = 8;
  localparam int SIB_FULL = 16;
  localparam int SIB_FAMILY = 8;
  localparam int UROW_BYTES = 32;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_KEY_STATUS = 8'h07;
  localparam logic [7:0] IDX_RESET_REQ = 8'h08;
  localparam logic [7:0] IDX_SYS_CTRL = 8'h0a;
  localparam logic [7:0] IDX_SYS_STATUS = 8'h0b;
  localparam int BIT_ERASE_KEY = 3;
  localparam int BIT_PROG_KEY = 4;
  localparam int BIT_UROW_KEY = 5;
  localparam int BIT_UROW_DONE = 1;
  localparam int BIT_LOCK = 0;
  localparam int BIT_UROW_ACTIVE = 2;
  localparam int BIT_PROG_ACTIVE = 3;
  localparam int BIT_RST_SYS = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RESET_RELEASE = 8'h00;

  typedef struct packed {
    logic erase;
    logic prog;
    logic urow;
  } dkac_keys_t;

  typedef enum {DKAC_IDLE, DKAC_ERASE, DKAC_PROG, DKAC_UROW, DKAC_COPY} dkac_mode_t;
endpackage

// file: logic/dkac_top.sv
// debug key access control: keys, info block, reset request, user-row buffer
`timescale 1ns/1ps
module dkac_top import dkac_pkg::*; #(
  parameter logic [7:0] RESET_SIGNATURE = 8'ha5, // arbitrary value
  parameter logic [127:0] SIB_ROM = 128'h0 // info bytes, byte 0 in low bits
) (
  input wire logic clock, // 200 mhz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic iface_disable, // link disable, cancels erase key
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic key_start, // key transfer begins
  input wire logic key_valid, // key byte strobe
  input wire logic [7:0] key_byte, // key byte
  input wire logic sib_req, // info block request pulse
  input wire logic sib_size16, // 1: 16 bytes, 0: 8 bytes
  input wire logic sib_ready, // framer takes info byte
  output logic sib_valid, // info byte valid
  output logic [7:0] sib_byte, // info byte, ascii
  input wire logic synch_pin, // raw link pin
  output logic synch_event, // level event per synch rising edge
  input wire logic lock_in, // lock bits from memory
  input wire logic erase_done, // chip erase finished pulse
  input wire logic prog_done, // programming done pulse
  output logic sys_reset, // system reset
  output logic erase_start, // start chip erase pulse
  output logic bod_force, // force brown-out detector on
  output logic sysbus_grant, // system bus open to link
  output logic nvm_write_grant, // direct memory writes allowed
  input wire logic ram_wr_valid, // link ram write
  input wire logic [11:0] ram_wr_addr, // link ram write address
  input wire logic [7:0] ram_wr_data, // link ram write data
  output logic ram_rd_grant, // link ram reads allowed
  output logic urow_wr_valid, // user-row byte write
  output logic [4:0] urow_wr_addr, // user-row offset
  output logic [7:0] urow_wr_data // user-row byte
);
  dkac_keys_t key_hit;
  dkac_keys_t key_flag;
  dkac_mode_t mode;
  logic lock_flag;
  logic prog_active;
  logic urow_active;
  logic urow_done;
  logic [7:0] urow_buf [UROW_BYTES];
  logic [5:0] copy_idx;
  logic [4:0] sib_idx;
  logic [4:0] sib_last;
  logic synch_s1;
  logic synch_s2;
  logic synch_prev;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_idx;
  logic aw_bad;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rst_release;

  function automatic logic [7:0] reg_idx(input logic [31:0] addr);
    return addr[9:2];
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    return addr[1:0] == 2'h0 && addr[31:10] == 22'h0 &&
      (reg_idx(addr) == IDX_KEY_STATUS || reg_idx(addr) == IDX_RESET_REQ ||
       reg_idx(addr) == IDX_SYS_CTRL || reg_idx(addr) == IDX_SYS_STATUS);
  endfunction

  dkac_key_shift u_key (
    .clock(clock),
    .rst_n(rst_n),
    .key_start(key_start),
    .key_valid(key_valid),
    .key_byte(key_byte),
    .key_hit(key_hit)
  );

  // write channel: address and data taken in either order, response after both
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h0;
      aw_bad <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= reg_idx(s_axi_awaddr);
        aw_bad <= !mapped(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata <= 32'h0;
        if (mapped(s_axi_araddr)) begin
          case (reg_idx(s_axi_araddr))
            IDX_KEY_STATUS: begin
              s_axi_rdata[BIT_ERASE_KEY] <= key_flag.erase;
              s_axi_rdata[BIT_PROG_KEY] <= key_flag.prog;
              s_axi_rdata[BIT_UROW_KEY] <= key_flag.urow;
            end
            IDX_SYS_CTRL: s_axi_rdata[BIT_UROW_DONE] <= urow_done;
            IDX_SYS_STATUS: begin
              s_axi_rdata[BIT_LOCK] <= lock_flag;
              s_axi_rdata[BIT_UROW_ACTIVE] <= urow_active;
              s_axi_rdata[BIT_PROG_ACTIVE] <= prog_active;
              s_axi_rdata[BIT_RST_SYS] <= sys_reset;
            end
            default: s_axi_rdata <= 32'h0;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // reset request: signature asserts, 0x00 releases
  assign rst_release = wr_fire && !aw_bad && aw_idx == IDX_RESET_REQ && w_strb[0] &&
    w_data[7:0] == RESET_RELEASE && sys_reset;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sys_reset <= 1'b0;
    end else if (wr_fire && !aw_bad && aw_idx == IDX_RESET_REQ && w_strb[0]) begin
      if (w_data[7:0] == RESET_SIGNATURE) begin
        sys_reset <= 1'b1;
      end else if (w_data[7:0] == RESET_RELEASE) begin
        sys_reset <= 1'b0;
      end
    end
  end

  // key flags: a match sets, unmatched keys change nothing; set wins over clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      key_flag <= '0;
    end else begin
      if (key_hit.erase) begin
        key_flag.erase <= 1'b1;
      end else if (iface_disable) begin
        key_flag.erase <= 1'b0;
      end
      if (key_hit.prog) begin
        key_flag.prog <= 1'b1;
      end else if (prog_done) begin
        key_flag.prog <= 1'b0;
      end
      if (key_hit.urow) begin
        key_flag.urow <= 1'b1;
      end else if (wr_fire && !aw_bad && aw_idx == IDX_KEY_STATUS && w_strb[0] &&
                   w_data[BIT_UROW_KEY]) begin
        key_flag.urow <= 1'b0;
      end
    end
  end

  // mode sequencing; keys act when system reset is released
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode <= DKAC_IDLE;
      erase_start <= 1'b0;
      prog_active <= 1'b0;
      urow_active <= 1'b0;
      urow_done <= 1'b0;
      copy_idx <= 6'h0;
    end else begin
      erase_start <= 1'b0;
      case (mode)
        DKAC_IDLE: begin
          if (rst_release && key_flag.erase) begin
            mode <= DKAC_ERASE;
            erase_start <= 1'b1;
          end else if (rst_release && key_flag.prog && !lock_flag) begin
            mode <= DKAC_PROG;
            prog_active <= 1'b1;
          end else if (rst_release && key_flag.urow && lock_flag) begin
            mode <= DKAC_UROW;
            urow_active <= 1'b1;
          end
        end
        DKAC_ERASE: if (erase_done) mode <= DKAC_IDLE;
        DKAC_PROG: begin
          if (prog_done || rst_release) begin
            mode <= DKAC_IDLE;
            prog_active <= 1'b0;
          end
        end
        DKAC_UROW: begin
          if (wr_fire && !aw_bad && aw_idx == IDX_SYS_CTRL && w_strb[0] &&
              w_data[BIT_UROW_DONE]) begin
            mode <= DKAC_COPY;
            urow_done <= 1'b1;
            copy_idx <= 6'h0;
          end
        end
        DKAC_COPY: begin
          if (copy_idx == 6'(UROW_BYTES)) begin
            mode <= DKAC_IDLE;
            urow_active <= 1'b0;
            urow_done <= 1'b0;
          end else begin
            copy_idx <= copy_idx + 6'h1;
          end
        end
        default: mode <= DKAC_IDLE;
      endcase
    end
  end

  // lock flag follows the memory except while erase runs, and drops at its end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_flag <= 1'b1;
    end else if (erase_done && mode == DKAC_ERASE) begin
      lock_flag <= 1'b0;
    end else if (mode != DKAC_ERASE) begin
      lock_flag <= lock_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bod_force <= 1'b0;
      sysbus_grant <= 1'b0;
      nvm_write_grant <= 1'b0;
      ram_rd_grant <= 1'b0;
    end else begin
      bod_force <= mode == DKAC_ERASE || (mode == DKAC_IDLE && rst_release && key_flag.erase);
      sysbus_grant <= !lock_flag;
      nvm_write_grant <= !lock_flag;
      ram_rd_grant <= !urow_active;
    end
  end

  // user-row buffer: writes above 32 bytes are dropped silently
  always_ff @(posedge clock) begin
    if (mode == DKAC_UROW && ram_wr_valid && ram_wr_addr < 12'(UROW_BYTES)) begin
      urow_buf[ram_wr_addr[4:0]] <= ram_wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      urow_wr_valid <= 1'b0;
      urow_wr_addr <= 5'h0;
      urow_wr_data <= 8'h0;
    end else begin
      urow_wr_valid <= mode == DKAC_COPY && copy_idx < 6'(UROW_BYTES);
      urow_wr_addr <= copy_idx[4:0];
      urow_wr_data <= urow_buf[copy_idx[4:0]];
    end
  end

  // info block stream, one byte per accepted beat
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sib_valid <= 1'b0;
      sib_byte <= 8'h0;
      sib_idx <= 5'h0;
      sib_last <= 5'h0;
    end else if (sib_valid) begin
      if (sib_ready) begin
        if (sib_idx == sib_last) begin
          sib_valid <= 1'b0;
        end else begin
          sib_byte <= SIB_ROM[8 * (sib_idx + 5'h1) +: 8];
          sib_idx <= sib_idx + 5'h1;
        end
      end
    end else if (sib_req) begin
      sib_valid <= 1'b1;
      sib_byte <= SIB_ROM[7:0];
      sib_idx <= 5'h0;
      sib_last <= sib_size16 ? 5'(SIB_FULL - 1) : 5'(SIB_FAMILY - 1);
    end
  end

  // synch event: pin synchronised, rising edge held as a one-cycle level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      synch_s1 <= 1'b0;
      synch_s2 <= 1'b0;
      synch_prev <= 1'b0;
      synch_event <= 1'b0;
    end else begin
      synch_s1 <= synch_pin;
      synch_s2 <= synch_s1;
      synch_prev <= synch_s2;
      synch_event <= synch_s2 && !synch_prev;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  reset_assert_a: assert property (wr_fire && !aw_bad && aw_idx == IDX_RESET_REQ && w_strb[0] && w_data[7:0] == RESET_SIGNATURE |=> sys_reset) else $error("reset request ignored");
  reset_release_a: assert property (rst_release |=> !sys_reset) else $error("reset not released");
  erase_flag_a: assert property (key_hit.erase |=> key_flag.erase) else $error("erase key not flagged");
  no_match_a: assert property (key_hit == '0 && !iface_disable && !prog_done && !wr_fire |=> $stable(key_flag)) else $error("flag changed without match");
  lock_clear_a: assert property (mode == DKAC_ERASE && erase_done |=> !lock_flag ##1 sysbus_grant) else $error("lock not cleared after erase");
  bus_gate_a: assert property (lock_flag |=> !nvm_write_grant && !sysbus_grant) else $error("access granted while locked");
  bod_erase_a: assert property (mode == DKAC_ERASE |-> ##1 bod_force) else $error("detector not forced in erase");
  prog_lock_a: assert property (mode == DKAC_IDLE && rst_release && lock_flag && !key_flag.erase |=> !prog_active) else $error("prog active while locked");
  ram_block_a: assert property (urow_active |=> !ram_rd_grant) else $error("ram read open in user-row mode");
  copy_len_a: assert property ($rose(mode == DKAC_COPY) |-> ##[32:34] !urow_active) else $error("copy length wrong");
  sib_short_a: assert property (sib_req && !sib_valid && !sib_size16 ##2 sib_ready [*8] |=> !sib_valid) else $error("family readout too long");
  synch_a: assert property (synch_s2 && !synch_prev |=> synch_event) else $error("synch edge missed");

  erase_cov_c: cover property (erase_start ##[1:100] !lock_flag);
  urow_cov_c: cover property (urow_wr_valid && urow_wr_addr == 5'h1f);
  sib_cov_c: cover property (sib_valid && sib_ready && sib_idx == 5'hf);
  prog_cov_c: cover property ($rose(prog_active));
endmodule // dkac_top

// file: testbench/dkac_link_host.sv
// link-side host model: key bytes, info block readout, synch edges
`timescale 1ns/1ps
module dkac_link_host (
  input wire logic clock, // link clock
  output logic key_start, // key transfer begins
  output logic key_valid, // key byte strobe
  output logic [7:0] key_byte, // key byte
  output logic sib_req, // info block request
  output logic sib_size16, // 1: 16 bytes, 0: 8 bytes
  output logic sib_ready, // takes info byte
  input wire logic sib_valid, // info byte valid
  input wire logic [7:0] sib_byte, // info byte
  output logic synch_pin // raw link pin
);
  initial begin
    key_start = 1'b0;
    key_valid = 1'b0;
    key_byte = 8'h00;
    sib_req = 1'b0;
    sib_size16 = 1'b0;
    sib_ready = 1'b0;
    synch_pin = 1'b0;
  end
  localparam int KEY_LEN = 8;
  // idle byte lines show the inverse so a stale byte is never mistaken for data
  task automatic send_key(input logic [63:0] k);
    @(posedge clock);
    key_start <= 1'b1;
    @(posedge clock);
    key_start <= 1'b0;
    for (int i = 0; i < KEY_LEN; i++) begin
      key_valid <= 1'b1;
      key_byte <= k[8*i +: 8];
      @(posedge clock);
      key_valid <= 1'b0;
      key_byte <= ~k[8*i +: 8];
      @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask
  // long readouts toggle ready so each byte stalls once; short ones stream
  task automatic read_sib(input logic big, output logic [127:0] got, output int n);
    got = '0;
    n = 0;
    @(posedge clock);
    sib_req <= 1'b1;
    sib_size16 <= big;
    @(posedge clock);
    sib_req <= 1'b0;
    repeat (60) begin
      @(posedge clock);
      if (sib_valid === 1'b1 && sib_ready === 1'b1) begin
        if (n < 16) got[8*n +: 8] = sib_byte;
        n++;
      end
      sib_ready <= big ? ~sib_ready : 1'b1;
    end
    @(posedge clock);
    sib_ready <= 1'b0;
  endtask
  task automatic synch_edges(input int n);
    repeat (n) begin
      @(posedge clock);
      synch_pin <= 1'b1;
      repeat (4) @(posedge clock);
      synch_pin <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
endmodule // dkac_link_host

// file: testbench/test_debug_key_access_control.sv
// testbench: registers, keys, info block, user-row copy and synch events
`timescale 1ns/1ps
module test_debug_key_access_control import dkac_pkg::*; ();
  localparam logic [7:0] SIG = 8'h5a; // arbitrary signature value
  localparam logic [127:0] ROM = 128'h37332e31204b435652003132333435;
  logic clock, rst_n, iface_disable, lock_in, erase_done, prog_done;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic key_start, key_valid, sib_req, sib_size16, sib_ready, sib_valid, synch_pin, synch_event;
  logic [7:0] key_byte, sib_byte, ram_wr_data, urow_wr_data;
  logic sys_reset, erase_start, bod_force, sysbus_grant, nvm_write_grant, ram_wr_valid;
  logic ram_rd_grant, urow_wr_valid;
  logic [11:0] ram_wr_addr;
  logic [4:0] urow_wr_addr;
  logic [7:0] urow_got [32];
  logic [127:0] got;
  int n_errors, total_checks, n_events, n_erase, urow_n, e0, n;

  dkac_top #(.RESET_SIGNATURE(SIG), .SIB_ROM(ROM)) dkac_top_inst (
    .clock(clock), .rst_n(rst_n), .iface_disable(iface_disable),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_start(key_start),
    .key_valid(key_valid), .key_byte(key_byte), .sib_req(sib_req), .sib_size16(sib_size16),
    .sib_ready(sib_ready), .sib_valid(sib_valid), .sib_byte(sib_byte), .synch_pin(synch_pin),
    .synch_event(synch_event), .lock_in(lock_in), .erase_done(erase_done),
    .prog_done(prog_done), .sys_reset(sys_reset), .erase_start(erase_start),
    .bod_force(bod_force), .sysbus_grant(sysbus_grant), .nvm_write_grant(nvm_write_grant),
    .ram_wr_valid(ram_wr_valid), .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
    .ram_rd_grant(ram_rd_grant), .urow_wr_valid(urow_wr_valid), .urow_wr_addr(urow_wr_addr),
    .urow_wr_data(urow_wr_data));
  dkac_link_host dkac_link_host_inst (.clock(clock), .key_start(key_start),
    .key_valid(key_valid), .key_byte(key_byte), .sib_req(sib_req), .sib_size16(sib_size16),
    .sib_ready(sib_ready), .sib_valid(sib_valid), .sib_byte(sib_byte), .synch_pin(synch_pin));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (synch_event === 1'b1) n_events <= n_events + 1;
    if (erase_start === 1'b1) n_erase <= n_erase + 1;
    if (urow_wr_valid === 1'b1) begin
      urow_got[urow_wr_addr] <= urow_wr_data;
      urow_n <= urow_n + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] wd, input logic [1:0] resp);
    int i;
    @(posedge clock);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, resp});
    if (i == 200) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask
  task automatic axi_rd(input logic [7:0] idx);
    int i;
    @(posedge clock);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 200) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask
  // a poll that never matches is a hang: it ends the run
  task automatic expect_reg(input logic [7:0] idx, input logic [31:0] mask,
                            input logic [31:0] exp, input int tries);
    for (int i = 0; i < tries; i++) begin
      axi_rd(idx);
      if ((d & mask) === exp) break;
    end
    chk(d & mask, exp);
    if (tries > 1 && (d & mask) !== exp) results();
  endtask
  task automatic rst_pulse();
    axi_wr(IDX_RESET_REQ, {24'h0, SIG}, RESP_OKAY);
    chk(sys_reset, 1'b1);
    expect_reg(IDX_SYS_STATUS, 32'h1 << BIT_RST_SYS, 32'h1 << BIT_RST_SYS, 1);
    axi_wr(IDX_RESET_REQ, {24'h0, RESET_RELEASE}, RESP_OKAY);
    chk(sys_reset, 1'b0);
  endtask
  task automatic ram_wr(input logic [11:0] a, input logic [7:0] wd);
    @(posedge clock);
    ram_wr_valid <= 1'b1;
    ram_wr_addr <= a;
    ram_wr_data <= wd;
    @(posedge clock);
    ram_wr_valid <= 1'b0;
    ram_wr_data <= ~wd;
  endtask
  task automatic pulse_disable();
    @(posedge clock);
    iface_disable <= 1'b1;
    @(posedge clock);
    iface_disable <= 1'b0;
  endtask

  initial begin
    {rst_n, iface_disable, erase_done, prog_done, ram_wr_valid} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    lock_in = 1'b1;
    ram_wr_addr = 12'h000;
    ram_wr_data = 8'h00;
    {n_errors, total_checks, n_events, n_erase, urow_n} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    expect_reg(IDX_SYS_STATUS, 32'h2f, 32'h1 << BIT_LOCK, 1);
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h0, 1);
    axi_rd(8'h40);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    chk({sysbus_grant, nvm_write_grant}, 2'b00);
    $display("test reset_and_map finished");
    dkac_link_host_inst.read_sib(1'b1, got, n);
    chk(n, SIB_FULL);
    chk(got[127:96] ^ ROM[127:96] | got[95:64] ^ ROM[95:64], 32'h0);
    chk(got[63:32] ^ ROM[63:32] | got[31:0] ^ ROM[31:0], 32'h0);
    dkac_link_host_inst.read_sib(1'b0, got, n);
    chk(n, SIB_FAMILY);
    chk(got[63:32] ^ ROM[63:32] | got[31:0] ^ ROM[31:0], 32'h0);
    $display("test info_block finished");
    e0 = n_events;
    dkac_link_host_inst.synch_edges(3);
    repeat (6) @(posedge clock);
    chk(n_events - e0, 3);
    $display("test synch_event finished");
    dkac_link_host_inst.send_key(KEY_UROW ^ 64'h80);
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h0, 1);
    dkac_link_host_inst.send_key(KEY_UROW);
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h1 << BIT_UROW_KEY, 1);
    rst_pulse();
    expect_reg(IDX_SYS_STATUS, 32'h4, 32'h1 << BIT_UROW_ACTIVE, 20);
    chk(ram_rd_grant, 1'b0);
    for (int i = 0; i < UROW_BYTES; i++) ram_wr(12'(i), 8'(8'h40 + i));
    ram_wr(12'h025, 8'hee);
    ram_wr(12'h800, 8'h11);
    axi_wr(IDX_SYS_CTRL, 32'h1 << BIT_UROW_DONE, RESP_OKAY);
    expect_reg(IDX_SYS_STATUS, 32'h4, 32'h0, 50);
    chk(urow_n, UROW_BYTES);
    for (int i = 0; i < UROW_BYTES; i++) chk({24'h0, urow_got[i]}, 32'h40 + i);
    chk(ram_rd_grant, 1'b1);
    axi_wr(IDX_KEY_STATUS, 32'h1 << BIT_UROW_KEY, RESP_OKAY);
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h0, 1);
    rst_pulse();
    $display("test user_row finished");
    dkac_link_host_inst.send_key(KEY_ERASE);
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h1 << BIT_ERASE_KEY, 1);
    pulse_disable();
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h0, 1);
    dkac_link_host_inst.send_key(KEY_ERASE);
    e0 = n_erase;
    rst_pulse();
    repeat (4) @(posedge clock);
    chk(n_erase - e0, 1);
    chk(bod_force, 1'b1);
    chk({sysbus_grant, nvm_write_grant}, 2'b00);
    erase_done <= 1'b1;
    lock_in <= 1'b0;
    @(posedge clock);
    erase_done <= 1'b0;
    expect_reg(IDX_SYS_STATUS, 32'h1, 32'h0, 20);
    repeat (3) @(posedge clock);
    chk(bod_force, 1'b0);
    chk({sysbus_grant, nvm_write_grant}, 2'b11);
    pulse_disable();
    $display("test chip_erase finished");
    dkac_link_host_inst.send_key(KEY_PROG);
    expect_reg(IDX_KEY_STATUS, 32'h38, 32'h1 << BIT_PROG_KEY, 1);
    rst_pulse();
    expect_reg(IDX_SYS_STATUS, 32'h8, 32'h1 << BIT_PROG_ACTIVE, 20);
    prog_done <= 1'b1;
    @(posedge clock);
    prog_done <= 1'b0;
    expect_reg(IDX_SYS_STATUS, 32'h8, 32'h0, 20);
    expect_reg(IDX_KEY_STATUS, 32'h10, 32'h0, 1);
    $display("test programming finished");
    results();
  end
endmodule // test_debug_key_access_control
